/* core/adc_dma_indirect_addr_gen.v */
// Converter DMA indirect address generator with scan mask and band gap
// Functional notes
// - With buffer mode select clear the converter works in indirect mode.
// - Indirect mode yields an 11-bit offset that the DMA ORs into its base.
// - Buffer space is equal contiguous sub-buffers, one slot per channel.
// - The buffer length field in control 4 picks 1 to 128 words a channel.
// - A 3 to 5 bit channel number sits right above the word offset.
// - The word offset is 0 to 7 bits wide, set by the sub-buffer size.
// - The offset's least significant bit is always a zero pad.
// - Bits above channel and word offset are zero, making 11 bits total.
// - The word position advances on writes, governed by samples per irq.
// - Only converted channels' slots are written; others stay untouched.
// - Each scan mask bit includes its channel when set, skips when clear.
// - A requested reference turns on after start-up; manual keeps it on.
// - With buffer mode select set results go to a sequential user area.
// - DMA support runs only while control 1 bit 11 enable is set.
`include "adc_dma_defines.vh"

module adc_dma_indirect_addr_gen #(
	parameter STARTUP_CYCLES = `BG_STARTUP_CYCLES,
	parameter DATA_W         = 12
) (
	// Clock and reset
	input  wire              aclk,
	input  wire              aresetn,
	// AXI4-Lite write address
	input  wire              s_axi_awvalid,
	output wire              s_axi_awready,
	input  wire [7:0]        s_axi_awaddr,
	// AXI4-Lite write data
	input  wire              s_axi_wvalid,
	output wire              s_axi_wready,
	input  wire [31:0]       s_axi_wdata,
	input  wire [3:0]        s_axi_wstrb,
	// AXI4-Lite write response
	output reg               s_axi_bvalid,
	input  wire              s_axi_bready,
	output reg  [1:0]        s_axi_bresp,
	// AXI4-Lite read address
	input  wire              s_axi_arvalid,
	output wire              s_axi_arready,
	input  wire [7:0]        s_axi_araddr,
	// AXI4-Lite read data
	output reg               s_axi_rvalid,
	input  wire              s_axi_rready,
	output reg  [31:0]       s_axi_rdata,
	output reg  [1:0]        s_axi_rresp,
	// Conversion results from the converter
	input  wire              conv_valid,
	output wire              conv_ready,
	input  wire [4:0]        conv_channel,
	input  wire [DATA_W-1:0] conv_result,
	// Transfer request to the DMA controller
	output reg               dma_valid,
	input  wire              dma_ready,
	output reg  [10:0]       indirect_offset,
	output reg  [15:0]       dma_data,
	output wire              periph_indirect_mode,
	// Scan selection to the sequencer
	output wire [30:0]       scan_channel_mask,
	// Band gap references
	input  wire [3:0]        ref_request,
	output wire [3:0]        ref_ready
);

	localparam IDX_W    = 7;
	localparam CHANNELS = 32;

	// Software registers
	reg [15:0] converter_control_1;
	reg [15:0] converter_control_2;
	reg [15:0] converter_control_4;
	reg [15:0] scan_select_low;
	reg [15:0] scan_select_high;
	reg [15:0] bandgap_ref_config;

	// Write channel holding state
	reg        aw_held;
	reg [7:0]  aw_addr;
	reg        w_held;
	reg [31:0] w_data;
	reg [3:0]  w_strb;

	// Per-channel word positions, driven from one register each
	wire [IDX_W-1:0] word_idx [0:CHANNELS-1];

	// Sequential position and last converted channel
	reg [4:0]       ext_idx;
	reg [4:0]       last_channel;

	// Control fields
	wire            converter_dma_enable;
	wire            dma_buffer_mode_sel;
	wire [4:0]      samples_per_interrupt;
	wire [2:0]      channel_buffer_len;
	wire            wr_fire;
	wire            take;
	wire            advance;
	wire            seq_step;
	wire [CHANNELS-1:0] chan_hit;

	// Offset arithmetic
	wire [IDX_W-1:0] len_mask;
	wire [IDX_W-1:0] wrap_at;
	wire [IDX_W-1:0] cur_idx;
	wire [11:0]     chan_shift;
	wire [11:0]     slot;
	wire [10:0]     pia_offset;
	wire [10:0]     ext_offset;
	genvar          g;

	assign converter_dma_enable  = converter_control_1[`CTRL1_DMA_EN_BIT];
	assign dma_buffer_mode_sel   = converter_control_1[`CTRL1_MODE_BIT];
	assign samples_per_interrupt =
		converter_control_2[`CTRL2_SMPI_MSB:`CTRL2_SMPI_LSB];
	assign channel_buffer_len    = converter_control_4[`CTRL4_BUFLEN_MSB:0];

	assign periph_indirect_mode = converter_dma_enable & ~dma_buffer_mode_sel;

	assign scan_channel_mask = {scan_select_high[14:0], scan_select_low};

	// Merge a write into a 16-bit register by byte lanes and writable mask
	function [15:0] merge16;
		input [15:0] old;
		input [31:0] data;
		input [3:0]  strb;
		input [15:0] wmask;
		reg   [15:0] lanes;
		begin
			lanes   = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
			merge16 = (old & ~lanes) | (data[15:0] & lanes);
		end
	endfunction

	// Address decode for writes and reads
	function mapped;
		input [7:0] addr;
		begin
			case (addr)
				`ADR_CTRL1, `ADR_CTRL2, `ADR_CTRL4, `ADR_SCAN_LOW,
				`ADR_SCAN_HIGH, `ADR_BANDGAP, `ADR_STATUS: mapped = 1'b1;
				default: mapped = 1'b0;
			endcase
		end
	endfunction

	// Address and data are taken in either order, one write at a time
	assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
	assign wr_fire       = aw_held & w_held & ~s_axi_bvalid;

	// Write channel capture and response
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held      <= 1'b0;
			aw_addr      <= 8'h00;
			w_held       <= 1'b0;
			w_data       <= 32'h00000000;
			w_strb       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= mapped(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Register writes; the status word ignores writes
	always @(posedge aclk) begin
		if (!aresetn) begin
			converter_control_1 <= `CTRL1_RESET;
			converter_control_2 <= `CTRL2_RESET;
			converter_control_4 <= `CTRL4_RESET;
			scan_select_low     <= `SCAN_RESET;
			scan_select_high    <= `SCAN_RESET;
			bandgap_ref_config  <= `BANDGAP_RESET;
		end else if (wr_fire) begin
			case (aw_addr)
				`ADR_CTRL1: converter_control_1 <= merge16(
					converter_control_1, w_data, w_strb, `CTRL1_MASK);
				`ADR_CTRL2: converter_control_2 <= merge16(
					converter_control_2, w_data, w_strb, `CTRL2_MASK);
				`ADR_CTRL4: converter_control_4 <= merge16(
					converter_control_4, w_data, w_strb, `CTRL4_MASK);
				`ADR_SCAN_LOW: scan_select_low <= merge16(
					scan_select_low, w_data, w_strb, `SCAN_LOW_MASK);
				`ADR_SCAN_HIGH: scan_select_high <= merge16(
					scan_select_high, w_data, w_strb, `SCAN_HIGH_MASK);
				`ADR_BANDGAP: bandgap_ref_config <= merge16(
					bandgap_ref_config, w_data, w_strb, `BANDGAP_MASK);
				default: ;
			endcase
		end
	end

	// Read channel, one read at a time, answer one cycle after the address
	assign s_axi_arready = ~s_axi_rvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
			case (s_axi_araddr)
				`ADR_CTRL1:     s_axi_rdata <= {16'h0000, converter_control_1};
				`ADR_CTRL2:     s_axi_rdata <= {16'h0000, converter_control_2};
				`ADR_CTRL4:     s_axi_rdata <= {16'h0000, converter_control_4};
				`ADR_SCAN_LOW:  s_axi_rdata <= {16'h0000, scan_select_low};
				`ADR_SCAN_HIGH: s_axi_rdata <= {16'h0000, scan_select_high};
				`ADR_BANDGAP:   s_axi_rdata <= {16'h0000, bandgap_ref_config};
				`ADR_STATUS:    s_axi_rdata <= {19'h00000, last_channel,
					3'h0, dma_valid, ref_ready};
				default:        s_axi_rdata <= 32'h00000000;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	assign len_mask = (7'h7f >> (3'd7 - channel_buffer_len));

	// wrap at buffer end or sample count, whichever comes first
	assign wrap_at = ({2'b00, samples_per_interrupt} < len_mask) ?
		{2'b00, samples_per_interrupt} : len_mask;

	assign cur_idx = word_idx[conv_channel] & len_mask;

	// channel number right above the word index
	assign chan_shift = {7'h00, conv_channel} << channel_buffer_len;
	assign slot       = chan_shift | {5'h00, cur_idx};

	// zero fill above, zero pad below, 11 bits
	assign pia_offset = {slot[9:0], 1'b0};

	assign ext_offset = {5'h00, ext_idx, 1'b0};

	// A new result is taken only when the DMA output is free or draining
	assign conv_ready = ~dma_valid | dma_ready;
	assign take       = conv_valid & conv_ready;

	// Result register towards the DMA controller
	always @(posedge aclk) begin
		if (!aresetn) begin
			dma_valid       <= 1'b0;
			indirect_offset <= 11'h000;
			dma_data        <= 16'h0000;
			last_channel    <= 5'h00;
		end else if (take && converter_dma_enable) begin
			dma_valid    <= 1'b1;
			dma_data     <= {{(16 - DATA_W){1'b0}}, conv_result};
			last_channel <= conv_channel;
			if (dma_buffer_mode_sel)
				indirect_offset <= ext_offset;
			else
				indirect_offset <= pia_offset;
		end else if (dma_ready) begin
			dma_valid <= 1'b0;
		end
	end

	// Which position moves on a take
	assign chan_hit = {{(CHANNELS-1){1'b0}}, 1'b1} << conv_channel;
	assign advance  = take & converter_dma_enable & ~dma_buffer_mode_sel;
	assign seq_step = take & converter_dma_enable & dma_buffer_mode_sel;

	generate
		for (g = 0; g < CHANNELS; g = g + 1) begin : gen_pos
			reg [IDX_W-1:0] pos;

			always @(posedge aclk) begin
				if (!aresetn) begin
					pos <= {IDX_W{1'b0}};
				end else if (advance && chan_hit[g]) begin
					if (cur_idx >= wrap_at)
						pos <= {IDX_W{1'b0}};
					else
						pos <= cur_idx + 7'h01;
				end
			end

			assign word_idx[g] = pos;
		end
	endgenerate

	// sequential position shared by all channels
	always @(posedge aclk) begin
		if (!aresetn) begin
			ext_idx <= 5'h00;
		end else if (seq_step) begin
			if (ext_idx >= samples_per_interrupt)
				ext_idx <= 5'h00;
			else
				ext_idx <= ext_idx + 5'h01;
		end
	end

	generate
		for (g = 0; g < 4; g = g + 1) begin : gen_ref
			ref_startup_timer #(
				.STARTUP_CYCLES (STARTUP_CYCLES),
				.CNT_W          (32)
			) u_timer (
				.aclk           (aclk),
				.aresetn        (aresetn),
				.manual_on      (bandgap_ref_config[g]),
				.module_request (ref_request[g]),
				.ready          (ref_ready[g])
			);
		end
	endgenerate

endmodule

/* core/adc_dma_defines.vh */
// Register map, field positions, reset values and timing for the DMA block
`ifndef ADC_DMA_DEFINES_VH
`define ADC_DMA_DEFINES_VH

// Register byte addresses
`define ADR_CTRL1         8'h00
`define ADR_CTRL2         8'h04
`define ADR_CTRL4         8'h08
`define ADR_SCAN_LOW      8'h0c
`define ADR_SCAN_HIGH     8'h10
`define ADR_BANDGAP       8'h14
`define ADR_STATUS        8'h18

// Field positions
`define CTRL1_DMA_EN_BIT  11
`define CTRL1_MODE_BIT    12
`define CTRL2_SMPI_LSB    2
`define CTRL2_SMPI_MSB    6
`define CTRL4_BUFLEN_MSB  2
`define BG_GENERAL_BIT    0
`define BG_CMP_BIT        1
`define BG_CONV_BIT       2
`define BG_USB_BIT        3
`define STAT_PENDING_BIT  4
`define STAT_CHAN_LSB     8
`define STAT_CHAN_MSB     12

// Writable bit masks
`define CTRL1_MASK        16'h1800
`define CTRL2_MASK        16'h007c
`define CTRL4_MASK        16'h0007
`define SCAN_LOW_MASK     16'hffff
`define SCAN_HIGH_MASK    16'h77ff
`define BANDGAP_MASK      16'h000f

// Reset values
`define CTRL1_RESET       16'h0000
`define CTRL2_RESET       16'h0000
`define CTRL4_RESET       16'h0000
`define SCAN_RESET        16'h0000
`define BANDGAP_RESET     16'h0000

// Bus responses
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

// Band gap start-up time and its cycle count, rounded up
`define CLK_MHZ           25
`define BG_STARTUP_NS     1000000
`define BG_STARTUP_CYCLES ((`BG_STARTUP_NS * `CLK_MHZ + 999) / 1000)

`endif

/* core/ref_startup_timer.v */
// Start-up timer for one band gap reference
`include "adc_dma_defines.vh"

module ref_startup_timer #(
	parameter STARTUP_CYCLES = `BG_STARTUP_CYCLES,
	parameter CNT_W          = 16
) (
	// Clock and reset
	input  wire aclk,
	input  wire aresetn,
	// Power requests
	input  wire manual_on,
	input  wire module_request,
	// Reference settled
	output reg  ready
);

	localparam [31:0]      LAST_FULL = STARTUP_CYCLES - 1;
	localparam [CNT_W-1:0] LAST      = LAST_FULL[CNT_W-1:0];

	reg [CNT_W-1:0] count;
	wire            powered;

	// Powered by a manual enable or by a using module
	assign powered = manual_on | module_request;

	// Count settle time while powered, restart when powered down
	always @(posedge aclk) begin
		if (!aresetn) begin
			count <= {CNT_W{1'b0}};
			ready <= 1'b0;
		end else if (!powered) begin
			count <= {CNT_W{1'b0}};
			ready <= 1'b0;
		end else if (count == LAST) begin
			ready <= 1'b1;
		end else begin
			count <= count + 1'b1;
		end
	end

endmodule

/* testbench/addr_gen_props.sv */
// Bus, transfer and scan assertions for the address generator
module addr_gen_props (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Register bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	// Converter and DMA
	input wire logic        conv_valid,
	input wire logic        conv_ready,
	input wire logic        dma_valid,
	input wire logic        dma_ready,
	input wire logic [10:0] indirect_offset,
	input wire logic        periph_indirect_mode,
	input wire logic [30:0] scan_channel_mask
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Both write channels taken at one edge
	sequence wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// A result taken while indirect mode is on
	sequence conv_take;
		conv_valid && conv_ready && periph_indirect_mode;
	endsequence
	a_wr_resp_time: assert property (wr_both |=> ##1 s_axi_bvalid)
		else $error("write response not two cycles after take");
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before taken");
	a_rd_resp_time: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("read data not one cycle after take");
	a_conv_flow: assert property (
		conv_ready == (!dma_valid || dma_ready))
		else $error("converter ready wrong for transfer state");
	a_dma_hold: assert property (
		dma_valid && !dma_ready |=> dma_valid && $stable(indirect_offset))
		else $error("transfer changed before accepted");
	a_offset_pad: assert property (
		dma_valid |-> !indirect_offset[0])
		else $error("offset low bit not zero");
	a_take_answer: assert property (conv_take |=> dma_valid)
		else $error("taken result gave no transfer");
	a_scan_gap: assert property (!scan_channel_mask[27])
		else $error("unimplemented scan bit set");
endmodule

bind adc_dma_indirect_addr_gen addr_gen_props u_addr_gen_props (.*);

/* testbench/dma_ctrl_model.sv */
// DMA controller model that takes offsets and forms addresses
module dma_ctrl_model (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Random stall select from the bench
	input  wire logic        stall_en,
	// Transfer from the converter side
	input  wire logic        dma_valid,
	output logic             dma_ready = 1'b0,
	input  wire logic [10:0] indirect_offset,
	input  wire logic [15:0] dma_data,
	// Last stored transfer
	output logic [15:0]      got_addr,
	output logic [15:0]      got_data,
	output integer           got_count
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [15:0] BASE = 16'h1000;
	integer pseed = 32'ha2f683a0;
	// Accept with optional random stalls and store each result
	always @(posedge aclk) begin
		if (!aresetn) begin
			dma_ready <= 1'b0;
			got_count <= 0;
		end else begin
			dma_ready <= !stall_en || $random(pseed) % 2 == 0;
			if (dma_valid && dma_ready) begin
				got_addr <= BASE | {5'h00, indirect_offset};
				got_data <= dma_data;
				got_count <= got_count + 1;
			end
		end
	end
endmodule

/* testbench/tb_adc_dma_indirect_addr_gen.sv */
// Self-checking bench for the indirect address generator
module tb_adc_dma_indirect_addr_gen;
	timeunit 1ns;
	timeprecision 1ns;
	// Clock, reset and register bus
	logic        aclk = 0, aresetn = 0;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0;
	logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb = 0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	// Converter, DMA and references
	logic        conv_valid = 0, conv_ready, stall_en = 0, ok;
	logic [4:0]  conv_channel = 0, ch;
	logic [11:0] conv_result = 0, res;
	logic        dma_valid, dma_ready, periph_indirect_mode;
	logic [10:0] indirect_offset;
	logic [15:0] dma_data, got_addr, got_data;
	logic [30:0] scan_channel_mask;
	logic [3:0]  ref_request = 0, ref_ready;
	logic [6:0]  idx [32];
	integer      got_count, fail_count = 0, checks_done = 0;
	integer      seed = 32'ha2f683a0;
	int          smpi, lim;

	always #20 aclk = ~aclk;

	adc_dma_indirect_addr_gen #(.STARTUP_CYCLES(8))
		u_adc_dma_indirect_addr_gen (.*);
	dma_ctrl_model u_dma_ctrl_model (.*);

	// Comparison, timeout and closing report
	task automatic chk(input string n, input logic [31:0] e, g);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic tmo;
		fail_count++;
		$display("MISMATCH wait exp done got timeout");
		end_sim();
	endtask
	task automatic do_reset;
		@(posedge aclk);
		aresetn <= 0;
		repeat (8) @(posedge aclk);
		aresetn <= 1;
	endtask

	// Register bus master cycles
	task automatic axi_wr(input [7:0] a, input [31:0] v, input [3:0] s,
		input [1:0] er);
		logic ta, tw, tb;
		logic [1:0] r;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		tb = 0;
		for (int i = 0; i < 40 && !tb; i++) begin
			@(negedge aclk);
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			tb = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 0;
			if (tw) s_axi_wvalid <= 0;
		end
		s_axi_bready <= 0;
		if (!tb) tmo();
		chk("bresp", er, r);
	endtask
	task automatic rd_chk(input [7:0] a, input [31:0] e, input [1:0] er);
		logic ta, tr;
		logic [31:0] v;
		logic [1:0] r;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		tr = 0;
		for (int i = 0; i < 40 && !tr; i++) begin
			@(negedge aclk);
			ta = s_axi_arvalid & s_axi_arready;
			tr = s_axi_rvalid;
			v = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 0;
		end
		s_axi_rready <= 0;
		if (!tr) tmo();
		chk("rdata", e, v);
		chk("rresp", er, r);
	endtask

	// One conversion result; reports whether the DMA stored it
	task automatic convert(input [4:0] c, input [11:0] r, output logic o);
		integer n0;
		logic tk;
		n0 = got_count;
		@(posedge aclk);
		conv_channel <= c;
		conv_result <= r;
		conv_valid <= 1;
		tk = 0;
		for (int i = 0; i < 40 && !tk; i++) begin
			@(negedge aclk);
			tk = conv_ready;
			@(posedge aclk);
		end
		conv_valid <= 0;
		if (!tk) tmo();
		for (int i = 0; i < 20 && got_count == n0; i++) @(negedge aclk);
		o = got_count != n0;
	endtask

	// Zeros, channel, word index, zero pad, cut to eleven bits
	function automatic logic [10:0] exp_off(input [4:0] c, input [6:0] x,
		input [2:0] n);
		logic [12:0] v;
		v = ({8'h00, c} << n) | x;
		return {v[9:0], 1'b0};
	endfunction

	initial begin
		do_reset();
		// Reset values, unmapped place, read-only status
		for (int a = 0; a < 8'h1c; a += 4)
			rd_chk(a, 0, 2'b00);
		rd_chk(8'h1c, 0, 2'b10);
		axi_wr(8'h1c, 1, 4'hf, 2'b10);
		axi_wr(8'h18, 32'hffff, 4'hf, 0);
		rd_chk(8'h18, 0, 0);
		// Scan mask words and a single byte lane
		d = $random(seed);
		axi_wr(8'h0c, d, 4'hf, 0);
		axi_wr(8'h10, d, 4'hf, 0);
		axi_wr(8'h0c, ~d, 4'h2, 0);
		rd_chk(8'h10, d & 32'h77ff, 0);
		chk("scan", {d[14:0] & 15'h77ff, ~d[15:8], d[7:0]},
			scan_channel_mask);
		// Reference start-up on request, then manual enable
		ref_request <= 4'h4;
		repeat (4) @(negedge aclk);
		chk("ref", 0, ref_ready);
		repeat (8) @(negedge aclk);
		chk("ref", 4'h4, ref_ready);
		@(posedge aclk);
		ref_request <= 0;
		repeat (3) @(negedge aclk);
		chk("ref", 0, ref_ready);
		axi_wr(8'h14, 32'hffffffff, 4'hf, 0);
		repeat (12) @(negedge aclk);
		chk("ref", 4'hf, ref_ready);
		rd_chk(8'h14, 32'hf, 0);
		ref_request <= 4'hf;
		@(negedge aclk);
		chk("ref", 4'hf, ref_ready);
		@(posedge aclk);
		ref_request <= 0;
		// Every buffer length code with a random sample count
		for (int n = 0; n < 8; n++) begin
			do_reset();
			stall_en <= n[0];
			smpi = $random(seed) & 31;
			lim = (1 << n) - 1;
			if (smpi < lim) lim = smpi;
			axi_wr(8'h08, n, 4'hf, 0);
			axi_wr(8'h04, smpi << 2, 4'hf, 0);
			axi_wr(8'h00, 32'h800, 4'hf, 0);
			chk("pia", 1, periph_indirect_mode);
			for (int c = 0; c < 32; c++) idx[c] = 0;
			for (int k = 0; k < 12; k++) begin
				ch = 5'($random(seed));
				if (k < 4) ch = 3;
				res = 12'($random(seed));
				convert(ch, res, ok);
				chk("xfer", 1, ok);
				chk("addr", 16'h1000 | exp_off(ch, idx[ch], 3'(n)),
					got_addr);
				chk("data", res, got_data);
				idx[ch] = (idx[ch] >= lim) ? 0 : idx[ch] + 1;
			end
			rd_chk(8'h18, {19'h0, ch, 8'h00}, 0);
		end
		// Buffer mode select: shared sequential area
		do_reset();
		axi_wr(8'h04, 32'h4, 4'hf, 0);
		axi_wr(8'h00, 32'h1800, 4'hf, 0);
		chk("pia", 0, periph_indirect_mode);
		for (int k = 0; k < 3; k++) begin
			convert(5'(k * 11), 12'(k), ok);
			chk("seq", (k == 1) ? 16'h1002 : 16'h1000, got_addr);
		end
		// DMA enable clear drops results
		axi_wr(8'h00, 0, 4'hf, 0);
		convert(5'd5, 12'h5a5, ok);
		chk("xfer", 0, ok);
		end_sim();
	end
endmodule
